/* File: shared/instr_decode_pkg.sv */
package instr_decode_pkg;

  localparam int          OPCODE_W        = 14;
  localparam int          DATA_W          = 8;
  localparam int          INDEX_W         = 7;
  localparam int          TARGET_BIT_POS  = 7;
  localparam logic [5:0]  OP_OR_ACC       = 6'h04;
  localparam logic [5:0]  OP_COPY_REG     = 6'h08;
  localparam logic [6:0]  OP_STORE_ACC    = 7'h01;
  localparam logic [3:0]  OP_LOAD_IMM     = 4'hC;
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;

  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_e;

  typedef enum logic [2:0] {
    OPK_NONE  = 3'b000,
    OPK_OR    = 3'b001,
    OPK_COPY  = 3'b010,
    OPK_STORE = 3'b011,
    OPK_LOAD  = 3'b100
  } op_kind_e;

  typedef struct packed {
    op_kind_e            kind;
    logic                result_target_bit;
    logic [INDEX_W-1:0]  register_index;
    logic [DATA_W-1:0]   immediate_value;
  } decoded_s;

  typedef struct packed {
    logic                en;
    logic [INDEX_W-1:0]  index;
    logic [DATA_W-1:0]   data;
  } file_write_s;

endpackage

/* File: logic/opcode_field_decoder.sv */
module opcode_field_decoder
  import instr_decode_pkg::*;
(
  // Instruction word
  input  wire logic [OPCODE_W-1:0] opcode,
  // Decoded fields
  output decoded_s                 decoded
);

  always_comb begin
    decoded                   = '0;
    decoded.kind              = OPK_NONE;
    decoded.result_target_bit = opcode[TARGET_BIT_POS];
    decoded.register_index    = opcode[INDEX_W-1:0];
    decoded.immediate_value   = opcode[DATA_W-1:0];
    if (opcode[13:8] == OP_OR_ACC) begin
      decoded.kind = OPK_OR;
    end else if (opcode[13:8] == OP_COPY_REG) begin
      decoded.kind = OPK_COPY;
    end else if (opcode[13:7] == OP_STORE_ACC) begin
      decoded.kind = OPK_STORE;
    end else if (opcode[13:10] == OP_LOAD_IMM) begin
      decoded.kind = OPK_LOAD;
    end
  end

endmodule

/* File: logic/move_and_or_instruction_decode.sv */
// How it works
// - Opcode 000100 computes accumulator OR register.
// - OR result to accumulator or register.
// - Opcode 001000 copies register to chosen target.
// - Seven-bit index, one-bit target select.
// - Store accumulator to register, flags kept.
// - Opcode 1100xx loads immediate, flags kept.
// - Literal-load don't-care bits never matter.
// - One word, four phases Q1 to Q4.
// - Store reads Q2, processes Q3, writes Q4.
module move_and_or_instruction_decode
  import instr_decode_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Instruction stream, sampled in the decode phase
  input  wire logic [OPCODE_W-1:0] opcode,
  // File register read port, index is registered from the opcode in the decode phase
  output logic      [INDEX_W-1:0]  read_index_ff,
  input  wire logic [DATA_W-1:0]   read_data,
  // File register write port
  output logic                     file_write_en_ff,
  output logic      [INDEX_W-1:0]  file_write_index_ff,
  output logic      [DATA_W-1:0]   file_write_data_ff,
  // Core state
  output logic      [DATA_W-1:0]   accumulator_ff,
  output logic                     null_result_flag_ff,
  output logic      [1:0]          phase_ff,
  output logic                     instr_done_ff
);

  logic              rst_sync1_ff;
  logic              rst_sync2_ff;
  phase_e            phase_q_ff;
  phase_e            nxt_phase;
  decoded_s          dec_now;
  decoded_s          dec_ff;
  logic [DATA_W-1:0] operand_ff;
  logic [DATA_W-1:0] result_ff;
  logic [DATA_W-1:0] nxt_result;

  // The reset is released through two stages so that no flop leaves reset on a ragged edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  opcode_field_decoder opcode_field_decoder_i (
    .opcode  (opcode),
    .decoded (dec_now)
  );

  always_comb begin
    unique case (phase_q_ff)
      PH_DECODE:  nxt_phase = PH_READ;
      PH_READ:    nxt_phase = PH_PROCESS;
      PH_PROCESS: nxt_phase = PH_WRITE;
      PH_WRITE:   nxt_phase = PH_DECODE;
    endcase
  end

  // Each instruction takes exactly one pass through the four phases.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      phase_q_ff <= PH_DECODE;
    end else begin
      phase_q_ff <= nxt_phase;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      dec_ff        <= '0;
      read_index_ff <= '0;
    end else if (phase_q_ff == PH_DECODE) begin
      dec_ff        <= dec_now;
      read_index_ff <= dec_now.register_index;
    end
  end

  // The register file answers within the read phase; its data is caught at the end of it.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      operand_ff <= '0;
    end else if (phase_q_ff == PH_READ) begin
      operand_ff <= (dec_ff.kind == OPK_LOAD) ? dec_ff.immediate_value
                  : (dec_ff.kind == OPK_STORE) ? accumulator_ff
                  : read_data;
    end
  end

  always_comb begin
    unique case (dec_ff.kind)
      OPK_OR:  nxt_result = accumulator_ff | operand_ff;
      default: nxt_result = operand_ff;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      result_ff <= '0;
    end else if (phase_q_ff == PH_PROCESS) begin
      result_ff <= nxt_result;
    end
  end

  logic to_file;
  logic to_acc;
  logic sets_flag;
  assign to_file   = (dec_ff.kind == OPK_STORE)
                   || (((dec_ff.kind == OPK_OR) || (dec_ff.kind == OPK_COPY))
                       && dec_ff.result_target_bit);
  assign to_acc    = (dec_ff.kind == OPK_LOAD)
                   || (((dec_ff.kind == OPK_OR) || (dec_ff.kind == OPK_COPY))
                       && !dec_ff.result_target_bit);
  assign sets_flag = (dec_ff.kind == OPK_OR) || (dec_ff.kind == OPK_COPY);

  // Results leave only in the write phase, so a read and a write of one register never collide.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      file_write_en_ff    <= 1'b0;
      file_write_index_ff <= '0;
      file_write_data_ff  <= '0;
    end else begin
      file_write_en_ff <= (phase_q_ff == PH_WRITE) && to_file;
      if ((phase_q_ff == PH_WRITE) && to_file) begin
        file_write_index_ff <= dec_ff.register_index;
        file_write_data_ff  <= result_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      accumulator_ff <= ACC_RESET;
    end else if ((phase_q_ff == PH_WRITE) && to_acc) begin
      accumulator_ff <= result_ff;
    end
  end

  // Store and load leave the flag alone.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      null_result_flag_ff <= 1'b0;
    end else if ((phase_q_ff == PH_WRITE) && sets_flag) begin
      null_result_flag_ff <= (result_ff == '0);
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      phase_ff      <= PHASE_RESET;
      instr_done_ff <= 1'b0;
    end else begin
      phase_ff      <= nxt_phase;
      instr_done_ff <= (phase_q_ff == PH_WRITE);
    end
  end

  AST_PHASE_CYCLE: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_DECODE) |=> (phase_q_ff == PH_READ) ##1 (phase_q_ff == PH_PROCESS)
      ##1 (phase_q_ff == PH_WRITE) ##1 (phase_q_ff == PH_DECODE))
    else $error("phase sequence broken");

  AST_OR_RESULT: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_PROCESS && dec_ff.kind == OPK_OR)
      |=> (result_ff == ($past(accumulator_ff) | $past(operand_ff))))
    else $error("or result wrong");

  AST_OR_TARGET: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_WRITE && dec_ff.kind == OPK_OR && !dec_ff.result_target_bit)
      |=> (accumulator_ff == $past(result_ff)) && !file_write_en_ff)
    else $error("or to accumulator wrong");

  AST_COPY_SELF: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_READ && dec_ff.kind == OPK_COPY && dec_ff.result_target_bit)
      ##3 1'b1 |-> file_write_en_ff && (file_write_data_ff == $past(operand_ff, 2))
      && (file_write_index_ff == read_index_ff))
    else $error("copy to itself wrong");

  AST_INDEX_CAPTURE: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_DECODE) |=> (read_index_ff == $past(opcode[INDEX_W-1:0])))
    else $error("index not captured");

  AST_STORE_FLAGS: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_WRITE && dec_ff.kind == OPK_STORE)
      |=> $stable(null_result_flag_ff) && file_write_en_ff
      && (file_write_data_ff == $past(result_ff)))
    else $error("store wrong");

  AST_LOAD_IMM: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_DECODE && opcode[13:10] == OP_LOAD_IMM)
      |-> ##4 (accumulator_ff == $past(opcode[DATA_W-1:0], 4)) && $stable(null_result_flag_ff))
    else $error("load immediate wrong");

  AST_LOAD_DONTCARE: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_DECODE && opcode[13:10] == OP_LOAD_IMM) |=> (dec_ff.kind == OPK_LOAD))
    else $error("load not decoded");

  AST_STORE_WRITE_Q4: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    file_write_en_ff |-> ($past(phase_q_ff) == PH_WRITE))
    else $error("write outside write phase");

  AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_WRITE && (dec_ff.kind == OPK_OR || dec_ff.kind == OPK_COPY))
      |=> (null_result_flag_ff == ($past(result_ff) == 8'h00)))
    else $error("zero flag wrong");

  AST_COPY_DECODE: assert property (@(posedge clk) disable iff (!rst_sync2_ff)
    (phase_q_ff == PH_DECODE && opcode[13:8] == OP_COPY_REG) |=> (dec_ff.kind == OPK_COPY))
    else $error("copy not decoded");

endmodule

/* File: bench/test_move_and_or_instruction_decode.sv */
module test_move_and_or_instruction_decode
  import instr_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk;
  logic                rst_n;
  logic [OPCODE_W-1:0] opcode;
  logic [INDEX_W-1:0]  read_index_ff;
  logic [DATA_W-1:0]   read_data;
  logic                file_write_en_ff;
  logic [INDEX_W-1:0]  file_write_index_ff;
  logic [DATA_W-1:0]   file_write_data_ff;
  logic [DATA_W-1:0]   accumulator_ff;
  logic                null_result_flag_ff;
  logic [1:0]          phase_ff;
  logic                instr_done_ff;
  logic [DATA_W-1:0]   mem [128];
  logic [DATA_W-1:0]   e_acc;
  logic                e_flag;
  int                  bad_count;
  int                  cmp_count;

  move_and_or_instruction_decode move_and_or_instruction_decode_i (
    .clk                 (clk),
    .rst_n               (rst_n),
    .opcode              (opcode),
    .read_index_ff       (read_index_ff),
    .read_data           (read_data),
    .file_write_en_ff    (file_write_en_ff),
    .file_write_index_ff (file_write_index_ff),
    .file_write_data_ff  (file_write_data_ff),
    .accumulator_ff      (accumulator_ff),
    .null_result_flag_ff (null_result_flag_ff),
    .phase_ff            (phase_ff),
    .instr_done_ff       (instr_done_ff)
  );

  // The file register array answers reads combinationally, as the read port expects.
  assign read_data = mem[read_index_ff];

  always @(posedge clk) begin
    if (file_write_en_ff === 1'b1) begin
      mem[file_write_index_ff] <= file_write_data_ff;
    end
  end

  always #4 clk = ~clk;

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Issues one word in the decode phase and judges the state four edges later.
  task automatic exec(input logic [13:0] op, input logic we, input logic [6:0] idx,
                      input logic [7:0] wd);
    for (int i = 0; i < 8 && phase_ff !== 2'h0; i++) begin
      @(posedge clk);
      #1;
    end
    opcode = op;
    repeat (4) @(posedge clk);
    #1;
    check(14'(phase_ff), 14'h0000);
    check(14'(instr_done_ff), 14'h0001);
    check(14'(read_index_ff), 14'(op[INDEX_W-1:0]));
    check(14'(accumulator_ff), 14'(e_acc));
    check(14'(null_result_flag_ff), 14'(e_flag));
    check(14'(file_write_en_ff), 14'(we));
    if (we) begin
      check(14'(file_write_index_ff), 14'(idx));
      check(14'(file_write_data_ff), 14'(wd));
    end
  endtask

  task automatic test_load();
    logic [7:0] vals [4];
    vals = '{8'h00, 8'h5A, 8'hFF, 8'h81};
    for (int k = 0; k < 4; k++) begin
      e_acc = vals[k];
      exec(14'h3000 | 14'(k << 8) | 14'(vals[k]), 1'b0, 7'h00, 8'h00);
    end
    $display("test_load done");
  endtask

  task automatic test_or();
    e_acc = 8'h91;
    exec(14'h3091, 1'b0, 7'h00, 8'h00);
    e_acc = 8'h93;
    exec(14'h0405, 1'b0, 7'h00, 8'h00);
    exec(14'h04FF, 1'b1, 7'h7F, 8'hDB);
    e_acc = 8'h00;
    exec(14'h3000, 1'b0, 7'h00, 8'h00);
    e_flag = 1'b1;
    exec(14'h0489, 1'b1, 7'h09, 8'h00);
    $display("test_or done");
  endtask

  task automatic test_copy();
    e_acc = 8'h13;
    e_flag = 1'b0;
    exec(14'h0805, 1'b0, 7'h00, 8'h00);
    e_flag = 1'b1;
    exec(14'h0889, 1'b1, 7'h09, 8'h00);
    e_acc = 8'hDB;
    e_flag = 1'b0;
    exec(14'h087F, 1'b0, 7'h00, 8'h00);
    $display("test_copy done");
  endtask

  task automatic test_store();
    e_flag = 1'b1;
    exec(14'h0889, 1'b1, 7'h09, 8'h00);
    e_acc = 8'h4F;
    exec(14'h304F, 1'b0, 7'h00, 8'h00);
    exec(14'h00C0, 1'b1, 7'h40, 8'h4F);
    exec(14'h3F00, 1'b0, 7'h00, 8'h00);
    exec(14'h0000, 1'b0, 7'h00, 8'h00);
    e_flag = 1'b0;
    exec(14'h0840, 1'b0, 7'h00, 8'h00);
    $display("test_store done");
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(2000 * 8);
    bad_count++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    opcode = 14'h0000;
    bad_count = 0;
    cmp_count = 0;
    e_acc = ACC_RESET;
    e_flag = 1'b0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'hA5;
    end
    mem[5] = 8'h13;
    mem[9] = 8'h00;
    mem[127] = 8'hDA;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    test_load();
    test_or();
    test_copy();
    test_store();
    complete_run();
  end
endmodule
